//--- pkg/ara_pkg.sv
// Shared constants, types and helpers for the alert-response block.
package ara_pkg;

    // Fixed upper four bits of the seven-bit slave address.
    localparam logic [3:0] ADDR_PREFIX = 4'h9;
    // Address byte of the alert response read, direction bit included.
    localparam logic [7:0] ARA_BYTE = 8'h19;

    // Link bit counter positions, counted in rising link clock edges.
    localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
    localparam logic [4:0] BIT_ACK = 5'h08;
    localparam logic [4:0] BIT_FIRST = 5'h09;
    localparam logic [4:0] BIT_LAST = 5'h10;
    localparam logic [4:0] BIT_END = 5'h11;

    // Clock cycles after reset release before the straps are captured.
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // Values of the thermostat behaviour bit, and its value after reset.
    localparam logic MODE_COMPARATOR = 1'h0;
    localparam logic MODE_INTERRUPT = 1'h1;
    localparam logic MODE_RESET = MODE_COMPARATOR;

    // Alert state: which limit is awaited and whether the alert is active.
    typedef enum logic [3:0] {
        AL_WAIT_HIGH = 4'h1,
        AL_HIGH = 4'h2,
        AL_WAIT_LOW = 4'h4,
        AL_LOW = 4'h8
    } alert_state_t;
    localparam alert_state_t AL_RESET = AL_WAIT_HIGH;

    // Bit of the returned byte that goes out while the counter reads c.
    function automatic logic tx_bit(input logic [7:0] b, input logic [4:0] c);
        logic [4:0] i;
        i = BIT_LAST - c;
        return b[i[2:0]];
    endfunction

endpackage

//--- pkg/link_if.sv
// Signals between the core-clock logic and the link-clock logic.
`timescale 1ns/100ps
interface link_if;
    logic [6:0] addr;
    logic cause;
    logic arm;
    logic won;

    // Core side drives the answer and reads the arbitration result.
    modport core (output addr, output cause, output arm, input won);
    // Link side reads the answer and reports a won arbitration.
    modport link (input addr, input cause, input arm, output won);
endinterface

//--- verilog/ara_link.sv
// Link-clock logic: address match, acknowledge and arbitrated address return.
`timescale 1ns/100ps
module ara_link (
    // Link clock and frame reset.
    input wire logic scl,
    input wire logic frame_rst_n,
    // Data line sense and open-drain enable.
    input wire logic sda_i,
    output logic sda_oe,
    // Core side.
    link_if.link lk
);

    typedef struct packed {
        logic arm_m;
        logic arm_s;
        logic cause_m;
        logic cause_s;
        logic [4:0] cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic hit;
        logic lost;
        logic won;
    } link_state_t;

    link_state_t q;
    link_state_t d;
    logic drv_q;
    logic drv_d;
    logic in_data;

    assign in_data = (q.cnt >= ara_pkg::BIT_FIRST) && (q.cnt <= ara_pkg::BIT_LAST);

    // Rising edges sample the line; the counter stops at the master's ack bit.
    always_comb begin
        d = q;
        d.arm_m = lk.arm;
        d.arm_s = q.arm_m;
        d.cause_m = lk.cause;
        d.cause_s = q.cause_m;
        if (q.cnt != ara_pkg::BIT_END) begin
            d.cnt = q.cnt + 5'h01;
        end
        if (q.cnt < ara_pkg::BIT_ACK) begin
            d.shift = {q.shift[6:0], sda_i};
        end
        if (q.cnt == ara_pkg::BIT_ADDR_LAST) begin
            d.hit = q.arm_s && ({q.shift[6:0], sda_i} == ara_pkg::ARA_BYTE);
            d.tx = {lk.addr, q.cause_s};
        end
        // A sent one read back as zero means another sensor won.
        if (q.hit && in_data && !q.lost && (sda_i != ara_pkg::tx_bit(q.tx, q.cnt))) begin
            d.lost = 1'b1;
        end
        if (q.cnt == ara_pkg::BIT_LAST) begin
            d.won = q.hit && !d.lost;
        end
    end

    // Falling edges change the driven bit, so the line is stable while the clock is high.
    always_comb begin
        drv_d = 1'b0;
        if (q.hit && (q.cnt == ara_pkg::BIT_ACK)) begin
            drv_d = 1'b1;
        end else if (q.hit && in_data && !q.lost) begin
            drv_d = !ara_pkg::tx_bit(q.tx, q.cnt);
        end
    end

    // The frame reset clears everything at each start, so no state leaks across frames.
    always_ff @(posedge scl or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Output register on the falling edge.
    always_ff @(negedge scl or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            drv_q <= 1'b0;
        end else begin
            drv_q <= drv_d;
        end
    end

    assign sda_oe = drv_q;
    assign lk.won = q.won;

    chk_ack_drive: assert property (@(posedge scl) disable iff (!frame_rst_n)
        (q.hit && q.cnt == ara_pkg::BIT_ACK) |-> sda_oe)
        else $error("Matched alert response not acknowledged.");

    chk_lost_quiet: assert property (@(posedge scl) disable iff (!frame_rst_n)
        q.lost |-> !sda_oe ##1 !q.won)
        else $error("Device kept driving after losing arbitration.");

endmodule

//--- verilog/alert_response.sv
// Alert behaviour, strap addressing and alert response for a temperature sensor.
`timescale 1ns/100ps
module alert_response (
    // Core clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Serial clock pin; also the link clock.
    input wire logic scl,
    // Serial data pin, open-drain.
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Alert pin, open-drain, active low on the wire.
    output logic alert_o,
    output logic alert_oe,
    // Address straps.
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic addr_strap_2,
    // Limit results from the converter, already fault-filtered.
    input wire logic over_high,
    input wire logic under_low,
    // Events from the register side.
    input wire logic reg_read,
    input wire logic shutdown,
    input wire logic gcall_reset,
    input wire logic mode_wr,
    input wire logic mode_wr_val,
    // Status.
    output logic thermostat_behaviour_bit,
    output logic alert_cause,
    output logic [6:0] slave_addr
);

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic [2:0] strap_m;
        logic [2:0] strap_s;
        logic [2:0] strap;
        logic [1:0] settle;
        logic strap_ok;
        logic won_m;
        logic won_s;
        logic start_seen;
        logic link_en;
        logic mode;
        ara_pkg::alert_state_t al;
    } core_state_t;

    core_state_t q;
    core_state_t d;

    link_if ifc ();

    logic start;
    logic stop;
    logic alert;
    logic ara_done;
    logic clear_int;

    // Bus conditions seen on the synchronised pins: data moving while clock is high.
    assign start = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
    assign stop = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;

    // A won response counts only when the frame closes with a stop.
    assign alert = (q.al == ara_pkg::AL_HIGH) || (q.al == ara_pkg::AL_LOW);
    assign ara_done = stop && q.won_s && (q.mode == ara_pkg::MODE_INTERRUPT);
    assign clear_int = reg_read || ara_done || shutdown;

    // Next-state logic of the core clock domain.
    always_comb begin
        d = q;
        // Pins cross into the core clock through two flip-flops each.
        d.scl_m = scl;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = sda_i;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.strap_m = {addr_strap_2, addr_strap_1, addr_strap_0};
        d.strap_s = q.strap_m;
        d.won_m = ifc.won;
        d.won_s = q.won_m;

        // Straps are caught once after release, after the synchroniser has filled.
        if (!q.strap_ok) begin
            d.settle = q.settle + 2'h1;
            if (q.settle == ara_pkg::STRAP_SETTLE) begin
                d.strap = q.strap_s;
                d.strap_ok = 1'b1;
            end
        end

        // The link logic is held in reset outside frames and pulsed at every start.
        d.start_seen = start;
        d.link_en = !start && !stop && (q.link_en || q.start_seen);

        // Behaviour bit; general call reset wins over a write in the same cycle.
        if (gcall_reset) begin
            d.mode = ara_pkg::MODE_COMPARATOR;
        end else if (mode_wr) begin
            d.mode = mode_wr_val;
        end

        // Alert sequencing for the two behaviours.
        if (q.mode == ara_pkg::MODE_COMPARATOR) begin
            case (q.al)
                ara_pkg::AL_WAIT_HIGH: begin
                    if (over_high) begin
                        d.al = ara_pkg::AL_HIGH;
                    end
                end
                ara_pkg::AL_HIGH: begin
                    if (!over_high && under_low) begin
                        d.al = ara_pkg::AL_WAIT_HIGH;
                    end
                end
                // A state left over from interrupt behaviour falls back to the high-limit level.
                default: begin
                    if (over_high) begin
                        d.al = ara_pkg::AL_HIGH;
                    end else begin
                        d.al = ara_pkg::AL_WAIT_HIGH;
                    end
                end
            endcase
        end else begin
            case (q.al)
                ara_pkg::AL_WAIT_HIGH: begin
                    if (over_high) begin
                        d.al = ara_pkg::AL_HIGH;
                    end
                end
                ara_pkg::AL_HIGH: begin
                    if (clear_int) begin
                        d.al = ara_pkg::AL_WAIT_LOW;
                    end
                end
                ara_pkg::AL_WAIT_LOW: begin
                    if (under_low) begin
                        d.al = ara_pkg::AL_LOW;
                    end
                end
                ara_pkg::AL_LOW: begin
                    if (clear_int) begin
                        d.al = ara_pkg::AL_WAIT_HIGH;
                    end
                end
                default: begin
                    d.al = ara_pkg::AL_RESET;
                end
            endcase
        end

        // General call reset clears the alert outright.
        if (gcall_reset) begin
            d.al = ara_pkg::AL_RESET;
        end
    end

    // State register of the core clock domain.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.mode <= ara_pkg::MODE_RESET;
            q.al <= ara_pkg::AL_RESET;
        end else begin
            q <= d;
        end
    end

    // What the link side answers with; address is static once captured.
    assign ifc.addr = {ara_pkg::ADDR_PREFIX, q.strap};
    assign ifc.cause = (q.al == ara_pkg::AL_HIGH);
    // Only an interrupt-mode alert takes part in responses; a loser is still armed.
    assign ifc.arm = alert && (q.mode == ara_pkg::MODE_INTERRUPT);

    // Link-clock logic; its reset is a core flop, released while the frame is open.
    ara_link u_link (
        .scl(scl),
        .frame_rst_n(q.link_en),
        .sda_i(sda_i),
        .sda_oe(sda_oe),
        .lk(ifc)
    );

    // Both pins only ever pull low.
    assign sda_o = 1'b0;
    assign alert_o = 1'b0;
    assign alert_oe = alert;

    // Status outputs.
    assign thermostat_behaviour_bit = q.mode;
    assign alert_cause = ifc.cause;
    assign slave_addr = ifc.addr;

    // Check triggers: the two response endings at the stop condition, and a read clearing a high alert.
    sequence s_stop_won;
        stop && q.won_s && q.mode && alert && !gcall_reset;
    endsequence

    sequence s_stop_lost;
        stop && !q.won_s && q.mode && alert && !reg_read && !shutdown && !gcall_reset;
    endsequence

    sequence s_int_clear_high;
        q.mode && (q.al == ara_pkg::AL_HIGH) && reg_read && !gcall_reset;
    endsequence

    // A cleared high alert waits for the low limit, a cleared low alert for the high one.
    property p_after_clear(s_cause);
        @(posedge clk) disable iff (!rst_n)
        s_cause |=> !alert_oe ##0 ((q.al == ara_pkg::AL_WAIT_LOW) == $past(alert_cause));
    endproperty

    chk_strap_capture: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(q.strap_ok) |-> (slave_addr == {ara_pkg::ADDR_PREFIX, $past(q.strap_s)}) ##1 $stable(slave_addr))
        else $error("Strap address not captured as expected.");

    chk_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_wr && !gcall_reset) |=> (thermostat_behaviour_bit == $past(mode_wr_val)))
        else $error("Behaviour bit did not take the written value.");

    chk_cmp_follow: assert property (@(posedge clk) disable iff (!rst_n)
        (!q.mode && over_high && !gcall_reset) |=> (alert_oe && alert_cause))
        else $error("Comparator alert did not follow the high limit.");

    chk_arm_mode: assert property (@(posedge clk) disable iff (!rst_n)
        !q.mode |-> !ifc.arm)
        else $error("Response armed outside interrupt behaviour.");

    chk_ara_clear: assert property (p_after_clear(s_stop_won))
        else $error("Winning responder kept its alert.");

    chk_lose_keep: assert property (@(posedge clk) disable iff (!rst_n)
        s_stop_lost |=> alert_oe ##0 $stable(alert_cause))
        else $error("Losing responder dropped its alert.");

    chk_gcr_mode: assert property (@(posedge clk) disable iff (!rst_n)
        gcall_reset |=> (!thermostat_behaviour_bit && !alert_oe))
        else $error("General call reset left interrupt behaviour or alert.");

    chk_int_rearm: assert property (p_after_clear(s_int_clear_high))
        else $error("Read did not clear the alert and await the low limit.");

    chk_low_cause: assert property (@(posedge clk) disable iff (!rst_n)
        (q.mode && (q.al == ara_pkg::AL_WAIT_LOW) && under_low && !gcall_reset) |=> (alert_oe && !alert_cause))
        else $error("Low-limit alert has the wrong cause bit.");

endmodule

//--- bench/ara_master.sv
// Behavioural bus master that polls the alert response address.
`timescale 1ns/100ps
module ara_master (
    // Bus lines as seen by the sensor.
    output logic scl,
    output wire sda,
    // Data pull-down enable of the sensor.
    input wire logic dut_oe
);
    logic low_q;

    // Open-drain data wire with a pull-up, so a released line reads high.
    assign sda = ~(low_q | dut_oe);

    // The link clock idles high and only runs inside frames.
    initial begin
        scl = 1'h1;
        low_q = 1'h0;
    end

    // One link clock period; data is set while the clock is low.
    task automatic bit_clk(input logic low, output logic seen);
        low_q = low;
        #40;
        scl = 1'h1;
        seen = sda;
        #80;
        scl = 1'h0;
        #40;
    endtask

    // Start, address byte, acknowledge, returned byte, no-ack and stop.
    // A rival byte other than FF plays a second sensor answering at once.
    task automatic frame(input logic [7:0] rival, output logic [7:0] got, output logic ack);
        logic s;
        low_q = 1'h1;
        #200;
        scl = 1'h0;
        #40;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(~ara_pkg::ARA_BYTE[i], s);
        end
        bit_clk(1'h0, s);
        ack = ~s;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(~rival[i], got[i]);
        end
        bit_clk(1'h0, s);
        low_q = 1'h1;
        #40;
        scl = 1'h1;
        #100;
        low_q = 1'h0;
        #200;
    endtask
endmodule

//--- bench/test_alert_response.sv
// Self-checking bench for the alert response block.
`timescale 1ns/100ps
module test_alert_response;
    // Event bits: mode write, value, over, under, read, shutdown, general reset.
    typedef struct packed {
        logic [6:0] ev;
        logic oe;
        logic cause;
        logic mode;
    } row_t;
    logic clk, rst_n, sda_o, sda_oe, alert_o, alert_oe, mode, cause, ack, scl;
    logic [2:0] strap;
    logic [6:0] ev, slave_addr;
    logic [7:0] got;
    wire sda;
    int failures, compares;
    row_t rows [16] = '{'{7'h10, 1'h1, 1'h1, 1'h0}, '{7'h04, 1'h1, 1'h1, 1'h0},
        '{7'h02, 1'h1, 1'h1, 1'h0}, '{7'h08, 1'h0, 1'h0, 1'h0}, '{7'h60, 1'h0, 1'h0, 1'h1},
        '{7'h10, 1'h1, 1'h1, 1'h1}, '{7'h04, 1'h0, 1'h0, 1'h1}, '{7'h10, 1'h0, 1'h0, 1'h1},
        '{7'h08, 1'h1, 1'h0, 1'h1}, '{7'h02, 1'h0, 1'h0, 1'h1}, '{7'h10, 1'h1, 1'h1, 1'h1},
        '{7'h61, 1'h0, 1'h0, 1'h0}, '{7'h60, 1'h0, 1'h0, 1'h1}, '{7'h10, 1'h1, 1'h1, 1'h1},
        '{7'h40, 1'h1, 1'h1, 1'h0}, '{7'h08, 1'h0, 1'h0, 1'h0}};

    alert_response u_alert_response (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe),
        .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
        .over_high(ev[4]), .under_low(ev[3]), .reg_read(ev[2]), .shutdown(ev[1]),
        .gcall_reset(ev[0]), .mode_wr(ev[6]), .mode_wr_val(ev[5]),
        .thermostat_behaviour_bit(mode), .alert_cause(cause), .slave_addr(slave_addr));

    ara_master u_ara_master (.scl(scl), .sda(sda), .dut_oe(sda_oe));

    // Core clock at 40 MHz.
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    // Compare and count; unknowns never match.
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle event, taken at the rising edge between the two falling edges.
    task automatic pulse(input logic [6:0] v);
        @(negedge clk);
        ev = v;
        @(negedge clk);
        ev = 7'h00;
    endtask

    // Reset with given straps, held three cycles, then check the reset state.
    task automatic do_reset(input logic [2:0] s);
        @(negedge clk);
        rst_n = 1'h0;
        strap = s;
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
        repeat (5) @(negedge clk);
        chk("slave_addr", {1'h0, slave_addr}, {1'h0, 4'h9, s});
        chk("mode", mode, 1'h0);
        chk("alert", alert_oe, 1'h0);
        chk("sda_o", sda_o, 1'h0);
        chk("alert_o", alert_o, 1'h0);
    endtask

    // One alert response frame; the alert clear lands a few cycles after stop.
    task automatic poll(input logic [7:0] rival, input logic [7:0] eg, input logic ea, input logic eal);
        u_ara_master.frame(rival, got, ack);
        repeat (10) @(negedge clk);
        chk("ack", ack, ea);
        chk("byte", got, eg);
        chk("alert", alert_oe, eal);
    endtask

    // Counts, verdict and end of run.
    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence: straps, event table, then bus cases.
    initial begin
        rst_n = 1'h0;
        strap = 3'h0;
        ev = 7'h00;
        failures = 0;
        compares = 0;
        for (int s = 0; s < 8; s++) begin
            do_reset(s[2:0]);
        end
        $display("test reset done");
        foreach (rows[i]) begin
            pulse(rows[i].ev);
            chk("alert", alert_oe, rows[i].oe);
            chk("mode", mode, rows[i].mode);
            if (rows[i].oe) begin
                chk("cause", cause, rows[i].cause);
            end
        end
        $display("test events done");
        // Comparator alert must not be answered; straps are now 7.
        pulse(7'h10);
        poll(8'hFF, 8'hFF, 1'h0, 1'h1);
        pulse(7'h08);
        $display("test comparator poll done");
        pulse(7'h60);
        pulse(7'h10);
        poll(8'hFF, 8'h9F, 1'h1, 1'h0);
        // Rival wins at bit 1; its later 1 shows we stopped driving.
        pulse(7'h08);
        poll(8'h9D, 8'h9D, 1'h1, 1'h1);
        poll(8'hFF, 8'h9E, 1'h1, 1'h0);
        $display("test bus done");
        print_verdict();
    end

    // Watchdog well beyond the expected run of about 18 us.
    initial begin
        #300000;
        failures++;
        print_verdict();
    end
endmodule
